// >>> design/qdl_regs.svh
`ifndef QDL_REGS_SVH
`define QDL_REGS_SVH

// serial frame layout
`define QDL_FRAME_BITS    24
`define QDL_CNT_LAST      5'd23
`define QDL_ADDR_HI       19
`define QDL_ADDR_LO       16
`define QDL_DATA_HI       15

// command addresses
`define QDL_ADDR_DATA3    4'h3
`define QDL_ADDR_GAIN     4'h4
`define QDL_ADDR_ZERO     4'h5
`define QDL_ADDR_GPIO     4'h6

// gpio command field positions
`define QDL_GPIO_DIR_LO   0
`define QDL_GPIO_VAL_LO   2

// reset values
`define QDL_GAIN_RST      16'h8000
`define QDL_ZERO_RST      16'h0000
`define QDL_UNI_RST_CODE  16'h0000
`define QDL_BIP_RST_CODE  16'h0000
`define QDL_BIP_FLIP      16'h8000

`endif

// >>> design/qdl_pkg.sv
package qdl_pkg;
  typedef logic [15:0] qdl_word_t;
  typedef enum logic [2:0] {
    QDL_T_DATA,
    QDL_T_GAIN,
    QDL_T_ZERO,
    QDL_T_GPIO,
    QDL_T_NONE
  } qdl_target_e;
endpackage

// >>> design/qdl_spi_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "qdl_regs.svh"

module qdl_spi_link
  import qdl_pkg::*;
(
  // serial link
  input  wire logic        link_sclk_in,
  input  wire logic        link_cs_n_in,
  input  wire logic        serial_data_in,
  output var  logic        serial_data_out,
  // frame hand-off
  output var  logic        frame_done_out,
  output var  logic [23:0] frame_word_out
);

  logic [23:0] sr_r;
  logic [23:0] sr_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        echo_r;
  logic        echo_nxt;
  logic [23:0] word_r;
  logic [23:0] word_nxt;

  // shift on each sclk rise; cs_n low is implied by the async clear
  always_comb begin
    sr_nxt   = {sr_r[22:0], serial_data_in};  // [R1]
    cnt_nxt  = (cnt_r == `QDL_CNT_LAST) ? 5'd0 : cnt_r + 5'd1;
    done_nxt = done_r | (cnt_r == `QDL_CNT_LAST);
    word_nxt = (cnt_r == `QDL_CNT_LAST) ? sr_nxt : word_r;
    echo_nxt = sr_r[22];                      // daisy-chain echo
  end

  // frame state is cleared while cs_n is high, since sclk may stop
  always_ff @(posedge link_sclk_in or posedge link_cs_n_in) begin
    if (link_cs_n_in) begin
      sr_r   <= 24'h000000;                   // [R1]
      cnt_r  <= 5'h00;
      done_r <= 1'b0;
      echo_r <= 1'b0;
    end else begin
      sr_r   <= sr_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
      echo_r <= echo_nxt;
    end
  end

  // held word survives cs_n rise so the core can still read it
  always_ff @(posedge link_sclk_in) begin
    word_r <= word_nxt;
  end

  assign serial_data_out = echo_r;
  assign frame_done_out  = done_r;
  assign frame_word_out  = word_r;

endmodule // qdl_spi_link
`default_nettype wire

// >>> design/qdl_top.sv
// Contract
// [R1] serial bits shift in only while chip select is low for the whole frame
// [R2] serial data output released to high impedance whenever chip select is high; the code releases it only three core clock cycles after cs_n rises
// [R3] load_latch_n low makes each dac latch follow its input data register
// [R4] each channel output level changes together with its dac latch value
// [R5] reset sets input registers and latches to the polarity-dependent reset code
// [R6] reset returns gain and zero calibration registers to their defaults
// [R7] two general-purpose pins readable as inputs, open-drain as outputs
// [R8] group a strap high selects unipolar, low selects bipolar for channels 0, 1
// [R9] unipolar data is straight binary, bipolar data is two's complement
// [R10] gpio output zero pulls pin low, output one releases it
`timescale 1ns/100ps
`default_nettype none
`include "qdl_regs.svh"

module qdl_top
  import qdl_pkg::*;
#(
  parameter int  NCH              = 4,
  parameter bit  GROUP_B_UNIPOLAR = 1'b1
) (
  // core clock, reset, enable
  input  wire logic               core_clk_in,
  input  wire logic               rstn_in,
  input  wire logic               core_ce_in,
  // serial link
  input  wire logic               link_sclk_in,
  input  wire logic               link_cs_n_in,
  input  wire logic               serial_data_in,
  output var  logic               serial_data_out,
  output var  logic               serial_data_oe_n_out,
  // load and strap pins
  input  wire logic               load_latch_n_in,
  input  wire logic               group_a_polarity_strap_in,
  // general-purpose pins
  input  wire logic [1:0]         gpio_pin_in,
  output var  logic [1:0]         gpio_pin_out,
  output var  logic [1:0]         gpio_pin_oe_n_out,
  // status and converter side
  output var  logic [1:0]         gpio_level_out,
  output var  logic               group_a_unipolar_out,
  output var  logic [NCH*16-1:0]  dac_level_out,
  output var  logic [15:0]        gain_cal_out,
  output var  logic [15:0]        zero_cal_out
);

  localparam int NSYNC = 5;

  // address decode of a received command
  function automatic qdl_target_e decode(input logic [3:0] a);
    if (a <= `QDL_ADDR_DATA3) begin
      decode = QDL_T_DATA;
    end else if (a == `QDL_ADDR_GAIN) begin
      decode = QDL_T_GAIN;
    end else if (a == `QDL_ADDR_ZERO) begin
      decode = QDL_T_ZERO;
    end else if (a == `QDL_ADDR_GPIO) begin
      decode = QDL_T_GPIO;
    end else begin
      decode = QDL_T_NONE;
    end
  endfunction

  // channel coding: bipolar two's complement to offset binary for the converter
  function automatic qdl_word_t to_level(input qdl_word_t code, input logic uni);
    to_level = uni ? code : (code ^ `QDL_BIP_FLIP);  // [R9]
  endfunction

  logic        frame_done;
  logic [23:0] frame_word;

  // link-domain receiver
  qdl_spi_link u_link (
    .link_sclk_in    (link_sclk_in),
    .link_cs_n_in    (link_cs_n_in),
    .serial_data_in  (serial_data_in),
    .serial_data_out (serial_data_out),
    .frame_done_out  (frame_done),
    .frame_word_out  (frame_word)
  );

  // two-stage synchronisers for frame_done and the pins entering the core domain, except gpio0
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s1_nxt;
  logic [NSYNC-1:0] s2_nxt;
  logic [NSYNC-1:0] sync_rst;

  assign pin_raw  = {frame_done, link_cs_n_in, load_latch_n_in,
                     group_a_polarity_strap_in, gpio_pin_in[1]};
  // reset values match idle pin levels, so no false edge or drive after reset
  assign sync_rst = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_comb begin
        s1_nxt[gi] = pin_raw[gi];
        s2_nxt[gi] = s1_r[gi];
      end
      always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
          s1_r[gi] <= sync_rst[gi];
          s2_r[gi] <= sync_rst[gi];
        end else if (core_ce_in) begin
          s1_r[gi] <= s1_nxt[gi];
          s2_r[gi] <= s2_nxt[gi];
        end
      end
    end
  endgenerate

  logic [1:0] g0_r;
  logic [1:0] g0_nxt;
  logic       done_q_r;
  logic       done_q_nxt;
  logic       uni_a;
  logic       load_n;
  logic       cs_n_s;
  logic       gpio1_s;
  logic       new_frame;

  assign done_q_nxt = s2_r[4];
  assign cs_n_s     = s2_r[3];
  assign load_n     = s2_r[2];
  assign uni_a      = s2_r[1];                       // [R8]
  assign gpio1_s    = s2_r[0];
  assign g0_nxt     = {g0_r[0], gpio_pin_in[0]};
  assign new_frame  = s2_r[4] & ~done_q_r;

  // gpio0 synchroniser and frame edge detector
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      g0_r     <= 2'b11;
      done_q_r <= 1'b0;
    end else if (core_ce_in) begin
      g0_r     <= g0_nxt;
      done_q_r <= done_q_nxt;
    end
  end

  // register state
  qdl_word_t   in_r    [NCH];
  qdl_word_t   in_nxt  [NCH];
  qdl_word_t   lat_r   [NCH];
  qdl_word_t   lat_nxt [NCH];
  logic [NCH*16-1:0] lvl_r;
  logic [NCH*16-1:0] lvl_nxt;
  qdl_word_t   gain_r;
  qdl_word_t   gain_nxt;
  qdl_word_t   zero_r;
  qdl_word_t   zero_nxt;
  logic [1:0]  dir_r;
  logic [1:0]  dir_nxt;
  logic [1:0]  val_r;
  logic [1:0]  val_nxt;
  logic [1:0]  oe_n_r;
  logic [1:0]  oe_n_nxt;
  logic [1:0]  glvl_r;
  logic [1:0]  glvl_nxt;
  logic        dout_oe_n_r;
  logic        dout_oe_n_nxt;
  logic        uni_r;
  qdl_target_e tgt;
  logic [3:0]  addr;
  qdl_word_t   wdata;
  logic        uni_ch;
  qdl_word_t   rst_code;

  assign addr  = frame_word[`QDL_ADDR_HI:`QDL_ADDR_LO];
  assign wdata = frame_word[`QDL_DATA_HI:0];
  assign tgt   = decode(addr);

  // command writes, load latches and level generation
  always_comb begin
    uni_ch   = 1'b0;
    rst_code = `QDL_UNI_RST_CODE;
    gain_nxt = gain_r;
    zero_nxt = zero_r;
    dir_nxt  = dir_r;
    val_nxt  = val_r;
    if (new_frame && tgt == QDL_T_GAIN) begin
      gain_nxt = wdata;
    end
    if (new_frame && tgt == QDL_T_ZERO) begin
      zero_nxt = wdata;
    end
    if (new_frame && tgt == QDL_T_GPIO) begin
      dir_nxt = wdata[`QDL_GPIO_DIR_LO +: 2];
      val_nxt = wdata[`QDL_GPIO_VAL_LO +: 2];
    end
    for (int c = 0; c < NCH; c++) begin
      uni_ch   = (c < 2) ? (uni_a | ~rstn_in) : GROUP_B_UNIPOLAR;  // [R8] unipolar in reset
      rst_code = uni_ch ? `QDL_UNI_RST_CODE : `QDL_BIP_RST_CODE;
      in_nxt[c] = in_r[c];
      if (new_frame && tgt == QDL_T_DATA && addr[1:0] == c[1:0]) begin
        in_nxt[c] = wdata;
      end
      lat_nxt[c] = load_n ? lat_r[c] : in_nxt[c];     // [R3]
      lvl_nxt[c*16 +: 16] = to_level(lat_nxt[c], uni_ch);  // [R4]
      if (!rstn_in) begin
        in_nxt[c]  = rst_code;                        // [R5]
        lat_nxt[c] = rst_code;                        // [R5]
        lvl_nxt[c*16 +: 16] = to_level(rst_code, uni_ch);
      end
    end
    if (!rstn_in) begin
      gain_nxt = `QDL_GAIN_RST;                       // [R6]
      zero_nxt = `QDL_ZERO_RST;                       // [R6]
      dir_nxt  = 2'b00;
      val_nxt  = 2'b11;
    end
    oe_n_nxt     = ~(dir_nxt & ~val_nxt);             // [R7] [R10]
    glvl_nxt     = {gpio1_s, g0_r[1]};                // [R7]
    dout_oe_n_nxt = cs_n_s;                           // [R2]
  end

  // register stage; reset values come from the next-state logic, except for glvl_r, dout_oe_n_r and uni_r
  always_ff @(posedge core_clk_in) begin
    if (core_ce_in || !rstn_in) begin
      for (int c = 0; c < NCH; c++) begin
        in_r[c]  <= in_nxt[c];
        lat_r[c] <= lat_nxt[c];
      end
      lvl_r      <= lvl_nxt;
      gain_r     <= gain_nxt;
      zero_r     <= zero_nxt;
      dir_r      <= dir_nxt;
      val_r      <= val_nxt;
      oe_n_r     <= oe_n_nxt;
      glvl_r     <= rstn_in ? glvl_nxt : 2'b11;
      dout_oe_n_r <= rstn_in ? dout_oe_n_nxt : 1'b1;  // [R2]
      uni_r      <= rstn_in ? uni_a : 1'b1;
    end
  end

  // outputs straight from flip-flops, except gpio_pin_out, which is tied low
  assign dac_level_out        = lvl_r;
  assign gain_cal_out         = gain_r;
  assign zero_cal_out         = zero_r;
  assign gpio_pin_out         = 2'b00;                // open-drain only pulls low
  assign gpio_pin_oe_n_out    = oe_n_r;
  assign gpio_level_out       = glvl_r;
  assign group_a_unipolar_out = uni_r;
  assign serial_data_oe_n_out = dout_oe_n_r;

endmodule // qdl_top
`default_nettype wire

// >>> bench/qdl_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module qdl_top_assertions #(parameter int NCH = 4) (
  // clock, reset and pins in
  input wire logic             core_clk_in, rstn_in, core_ce_in,
  input wire logic             link_sclk_in, link_cs_n_in, serial_data_in,
  input wire logic             load_latch_n_in, group_a_polarity_strap_in,
  input wire logic [1:0]       gpio_pin_in, gpio_pin_out, gpio_pin_oe_n_out, gpio_level_out,
  // outputs watched
  input wire logic             serial_data_out, serial_data_oe_n_out, group_a_unipolar_out,
  input wire logic [NCH*16-1:0] dac_level_out,
  input wire logic [15:0]      gain_cal_out, zero_cal_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  // reset values, checked while reset is held
  a_reset_cal: assert property (!rstn_in |=> gain_cal_out == 16'h8000
    && zero_cal_out == 16'h0000) else $error("calibration defaults wrong");
  a_reset_level: assert property (!rstn_in |=> dac_level_out == {NCH{16'h0000}}
    && group_a_unipolar_out) else $error("reset level wrong");
  a_reset_pins: assert property (!rstn_in |=> gpio_pin_oe_n_out == 2'h3
    && serial_data_oe_n_out) else $error("pins driven in reset");
  // serial output released once deselected
  a_dout_release: assert property (disable iff (!rstn_in)
    link_cs_n_in [*4] |=> serial_data_oe_n_out) else $error("data out driven while deselected");
  // strap and pin levels follow their inputs within three cycles
  a_strap_mode: assert property (disable iff (!rstn_in)
    $stable(group_a_polarity_strap_in) [*4] |=> group_a_unipolar_out
    == $past(group_a_polarity_strap_in)) else $error("polarity mode wrong");
  a_gpio_level: assert property (disable iff (!rstn_in)
    $stable(gpio_pin_in) [*4] |=> gpio_level_out == $past(gpio_pin_in))
    else $error("gpio level wrong");
  // open drain never drives high
  a_gpio_drain: assert property (disable iff (!rstn_in) gpio_pin_out == 2'h0)
    else $error("gpio drives high");
  // latch holds while load is high
  a_latch_hold: assert property (disable iff (!rstn_in)
    (load_latch_n_in && $stable(group_a_polarity_strap_in)) [*5] |=> $stable(dac_level_out))
    else $error("latch moved while held");
  // main scenarios
  c_frame: cover property (disable iff (!rstn_in) !link_cs_n_in ##1 link_cs_n_in);
  c_load: cover property (disable iff (!rstn_in) $fell(load_latch_n_in));
  c_drive: cover property (disable iff (!rstn_in) gpio_pin_oe_n_out != 2'h3);
endmodule // qdl_top_assertions
`default_nettype wire

// >>> bench/qdl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module qdl_host_model (
  // serial link driven by the host
  output var logic link_sclk_out,
  output var logic link_cs_n_out,
  output var logic host_data_out
);
  initial begin
    link_sclk_out = 1'b0;
    link_cs_n_out = 1'b1;
    host_data_out = 1'b0;
  end
  // one frame msb first, clock still outside the frame
  task automatic send(input logic [23:0] word, input int nbits);
    #7 link_cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      host_data_out = word[23-i];
      #24 link_sclk_out = 1'b1;
      #24 link_sclk_out = 1'b0;
    end
    #24 link_cs_n_out = 1'b1;
    host_data_out = ~host_data_out; // stale data is not left on the line
    #200;
  endtask
endmodule // qdl_host_model
`default_nettype wire

// >>> bench/tb_qdl_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_qdl_top;
  // design pins, named as the ports
  logic        core_clk_in = 1'b0, rstn_in = 1'b0, core_ce_in = 1'b1;
  logic        load_latch_n_in = 1'b1, group_a_polarity_strap_in = 1'b1;
  logic [1:0]  ext_n = 2'h3;
  wire logic   link_sclk_in, link_cs_n_in, serial_data_in;
  wire logic [1:0] gpio_pin_in;
  logic        serial_data_out, serial_data_oe_n_out, group_a_unipolar_out;
  logic [1:0]  gpio_pin_out, gpio_pin_oe_n_out, gpio_level_out;
  logic [63:0] dac_level_out;
  logic [15:0] gain_cal_out, zero_cal_out;
  int          err_total = 0, n_compared = 0;
  // open-drain pins with pull-up, also pulled low by the bench
  assign gpio_pin_in = (gpio_pin_oe_n_out | gpio_pin_out) & ext_n;
  always #20 core_clk_in = ~core_clk_in;
  qdl_top i_qdl_top (
    .core_clk_in               (core_clk_in),
    .rstn_in                   (rstn_in),
    .core_ce_in                (core_ce_in),
    .link_sclk_in              (link_sclk_in),
    .link_cs_n_in              (link_cs_n_in),
    .serial_data_in            (serial_data_in),
    .serial_data_out           (serial_data_out),
    .serial_data_oe_n_out      (serial_data_oe_n_out),
    .load_latch_n_in           (load_latch_n_in),
    .group_a_polarity_strap_in (group_a_polarity_strap_in),
    .gpio_pin_in               (gpio_pin_in),
    .gpio_pin_out              (gpio_pin_out),
    .gpio_pin_oe_n_out         (gpio_pin_oe_n_out),
    .gpio_level_out            (gpio_level_out),
    .group_a_unipolar_out      (group_a_unipolar_out),
    .dac_level_out             (dac_level_out),
    .gain_cal_out              (gain_cal_out),
    .zero_cal_out              (zero_cal_out)
  );
  qdl_host_model i_qdl_host_model (.link_sclk_out(link_sclk_in),
    .link_cs_n_out(link_cs_n_in), .host_data_out(serial_data_in));
  // shared helpers
  task automatic check(input string name, input logic [63:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic put(input logic [3:0] addr, input logic [15:0] data);
    i_qdl_host_model.send({4'h0, addr, data}, 24);
    cycles(6);
  endtask
  // scenarios
  task automatic t_defaults;
    check("gain", 16'h8000, gain_cal_out);
    check("zero", 16'h0000, zero_cal_out);
    check("levels", 64'h0, dac_level_out);
    check("gpio drive", 2'h3, gpio_pin_oe_n_out);
  endtask
  task automatic t_frames;
    fork
      i_qdl_host_model.send({8'h04, 16'h4321}, 23);
      begin
        cycles(20);
        check("dout drive", 1'b0, serial_data_oe_n_out);
      end
    join
    cycles(6);
    check("short frame", 16'h8000, gain_cal_out);
    check("dout release", 1'b1, serial_data_oe_n_out);
    check("echo idle", 1'b0, serial_data_out);
    // echo shows the first bit only from the 24th rise on
    fork
      i_qdl_host_model.send({4'h8, 4'h4, 16'h4321}, 24);
      begin
        repeat (23) @(posedge link_sclk_in);
        #5 check("echo early", 1'b0, serial_data_out);
        @(posedge link_sclk_in);
        #5 check("echo", 1'b1, serial_data_out);
      end
    join
    cycles(6);
    put(4'h5, 16'h00aa);
    check("gain", 16'h4321, gain_cal_out);
    check("zero", 16'h00aa, zero_cal_out);
  endtask
  task automatic t_load;
    for (int c = 0; c < 4; c++) put(c[3:0], 16'h1230 + c[15:0]);
    check("held", 64'h0, dac_level_out);
    load_latch_n_in = 1'b0;
    cycles(4);
    check("loaded", 64'h1233_1232_1231_1230, dac_level_out);
    load_latch_n_in = 1'b1;
  endtask
  task automatic t_bipolar;
    group_a_polarity_strap_in = 1'b0;
    load_latch_n_in = 1'b0;
    put(4'h0, 16'hffff);
    put(4'h1, 16'h8000);
    check("mode", 1'b0, group_a_unipolar_out);
    check("ch0 ch1", 32'h0000_7fff, dac_level_out[31:0]);
    check("ch2", 16'h1232, dac_level_out[47:32]);
    load_latch_n_in = 1'b1;
    group_a_polarity_strap_in = 1'b1;
  endtask
  task automatic t_gpio;
    put(4'h6, 16'h0007);
    check("gpio drive", 2'h1, gpio_pin_oe_n_out);
    check("gpio out", 2'h0, gpio_pin_out);
    check("gpio level", 2'h1, gpio_level_out);
    ext_n = 2'h2;
    cycles(4);
    check("gpio input", 2'h0, gpio_level_out);
    ext_n = 2'h3;
  endtask
  // mid-run reset, then a load shows the input registers were cleared
  task automatic t_reset;
    rstn_in = 1'b0;
    cycles(3);
    rstn_in = 1'b1;
    cycles(1);
    t_defaults();
    load_latch_n_in = 1'b0;
    cycles(4);
    check("inputs reset", 64'h0, dac_level_out);
    load_latch_n_in = 1'b1;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence, then a second reset in mid-run
  initial begin
    cycles(8);
    rstn_in = 1'b1;
    t_defaults();
    t_frames();
    t_load();
    t_bipolar();
    t_gpio();
    t_reset();
    complete_run();
  end
  // watchdog
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // tb_qdl_top
bind qdl_top qdl_top_assertions #(.NCH(NCH)) i_qdl_top_assertions (
  .core_clk_in               (core_clk_in),
  .rstn_in                   (rstn_in),
  .core_ce_in                (core_ce_in),
  .link_sclk_in              (link_sclk_in),
  .link_cs_n_in              (link_cs_n_in),
  .serial_data_in            (serial_data_in),
  .load_latch_n_in           (load_latch_n_in),
  .group_a_polarity_strap_in (group_a_polarity_strap_in),
  .gpio_pin_in               (gpio_pin_in),
  .gpio_pin_out              (gpio_pin_out),
  .gpio_pin_oe_n_out         (gpio_pin_oe_n_out),
  .gpio_level_out            (gpio_level_out),
  .serial_data_out           (serial_data_out),
  .serial_data_oe_n_out      (serial_data_oe_n_out),
  .group_a_unipolar_out      (group_a_unipolar_out),
  .dac_level_out             (dac_level_out),
  .gain_cal_out              (gain_cal_out),
  .zero_cal_out              (zero_cal_out)
);
`default_nettype wire
